// ===== common/aorm_pkg.sv
// shared constants and types for the output rate, alignment and lane mapper
package aorm_pkg;
    // datapath shape
    localparam int AORM_CH_N = 8;
    localparam int AORM_LANE_N = 16;
    localparam int AORM_WORD_W = 14;
    localparam int AORM_HALF_W = 7;
    localparam int AORM_MAP_W = 4;
    localparam int AORM_AVS_AW = 10;

    // register indices; byte address is four times the index
    localparam logic [7:0] AORM_IDX_SYNC_EN = 8'h02;
    localparam logic [7:0] AORM_IDX_PAT_ALIGN = 8'h25;
    localparam logic [7:0] AORM_IDX_MODE = 8'h27;
    localparam logic [7:0] AORM_IDX_STATUS = 8'h28;
    localparam logic [7:0] AORM_IDX_RATE = 8'h38;
    localparam logic [7:0] AORM_IDX_FORMAT = 8'h46;
    localparam logic [7:0] AORM_IDX_MAP_L0 = 8'h50;
    localparam logic [7:0] AORM_IDX_MAP_L1 = 8'h51;
    localparam logic [7:0] AORM_IDX_MAP_L2 = 8'h52;
    localparam logic [7:0] AORM_IDX_MAP_H0 = 8'h53;
    localparam logic [7:0] AORM_IDX_MAP_H1 = 8'h54;
    localparam logic [7:0] AORM_IDX_MAP_H2 = 8'h55;

    // field positions
    localparam int AORM_SYNC_EN_BIT = 13;
    localparam int AORM_PAT_ALIGN_BIT = 15;
    localparam int AORM_RATE_LSB = 0;
    localparam int AORM_TWOS_BIT = 2;
    localparam int AORM_MSB_FIRST_BIT = 3;
    localparam int AORM_MODE_TWO_WIRE_BIT = 0;
    localparam int AORM_MODE_RAMP_BIT = 1;
    localparam int AORM_MAP_F0 = 0;
    localparam int AORM_MAP_F1 = 4;
    localparam int AORM_MAP_F2 = 8;
    localparam int AORM_MAP_PD_BIT = 3;

    // reset values
    localparam logic [15:0] AORM_RST_CTRL = 16'h0000;
    localparam logic [15:0] AORM_RST_MAP_L0 = 16'h0210;
    localparam logic [15:0] AORM_RST_MAP_L1 = 16'h0543;
    localparam logic [15:0] AORM_RST_MAP_L2 = 16'h0076;
    localparam logic [15:0] AORM_RST_MAP_H0 = 16'h0567;
    localparam logic [15:0] AORM_RST_MAP_H1 = 16'h0234;
    localparam logic [15:0] AORM_RST_MAP_H2 = 16'h0001;

    // output word rate codes
    typedef enum logic [1:0] {
        AORM_RATE_FULL = 2'b00,
        AORM_RATE_HALF = 2'b01,
        AORM_RATE_QUARTER = 2'b10,
        AORM_RATE_EIGHTH = 2'b11
    } aorm_rate_t;

    // one sample word per converter channel
    typedef logic [AORM_CH_N-1:0][AORM_WORD_W-1:0] aorm_samples_t;

    // serial lane bits, one per lane of each pair
    typedef struct packed {
        logic [7:0] b;
        logic [7:0] a;
    } aorm_lanes_t;

    // word and power-down picked for one lane
    typedef struct packed {
        logic pd;
        logic [AORM_WORD_W-1:0] word;
    } aorm_lane_sel_t;
endpackage

// ===== rtl/aorm_rate_div.sv
// output word rate divider with alignment restart
`timescale 1ns/1ps
module aorm_rate_div
    import aorm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_tick,
    input wire logic i_align,
    input wire aorm_rate_t i_rate,
    // outputs
    output logic o_en,
    output logic [2:0] o_phase
);
    // low bits of the phase that must be zero for an output word
    logic [2:0] mask;
    logic [2:0] phase;

    // sub-multiple select
    assign mask = (i_rate == AORM_RATE_HALF) ? 3'h1 :
                  (i_rate == AORM_RATE_QUARTER) ? 3'h3 :
                  (i_rate == AORM_RATE_EIGHTH) ? 3'h7 : 3'h0;
    // alignment restarts the divider at phase zero
    assign phase = i_align ? 3'h0 : o_phase;

    // phase counts converter samples, enable marks the kept ones
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_phase <= 3'h0;
            o_en <= 1'b0;
        end
        else
        begin
            o_en <= i_tick & ((phase & mask) == 3'h0);
            o_phase <= i_tick ? 3'(phase + 3'h1) : phase;
        end
    end
endmodule

// ===== rtl/aorm_lane_ser.sv
// one serial output lane: load a word, shift it out a bit per cycle
`timescale 1ns/1ps
module aorm_lane_ser
    import aorm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // word load
    input wire logic i_load,
    input wire logic [AORM_WORD_W-1:0] i_word,
    input wire logic i_pd,
    input wire logic i_half,
    input wire logic i_msb_first,
    // lane pins
    output logic o_bit,
    output logic o_pd
);
    // shift register, lsb leaves first
    logic [AORM_WORD_W-1:0] sh;
    logic [AORM_WORD_W-1:0] load_word;

    // bit reversal over the full word width
    function automatic logic [AORM_WORD_W-1:0] rev(input logic [AORM_WORD_W-1:0] w);
        logic [AORM_WORD_W-1:0] r;
        r = '0;
        for (int i = 0; i < AORM_WORD_W; i++)
            r[i] = w[AORM_WORD_W-1-i];
        return r;
    endfunction

    // msb first reverses inside the active word length
    assign load_word = !i_msb_first ? i_word :
                       i_half ? (rev(i_word) >> AORM_HALF_W) : rev(i_word);

    // load or shift, powered-down lane stays low
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sh <= '0;
            o_pd <= 1'b1;
            o_bit <= 1'b0;
        end
        else
        begin
            if (i_load)
            begin
                sh <= load_word;
                o_pd <= i_pd;
            end
            else
                sh <= sh >> 1;
            o_bit <= ~o_pd & sh[0];
        end
    end
endmodule

// ===== rtl/aorm_top.sv
// converter output stage: rate, alignment, word format, lane mapping
`timescale 1ns/1ps
module aorm_top
    import aorm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [AORM_AVS_AW-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // converter samples
    input wire aorm_samples_t i_sample,
    input wire logic i_sample_valid,
    // alignment pulse pin
    input wire logic i_sync_pin,
    // serial lanes
    output aorm_lanes_t o_lanes,
    output aorm_lanes_t o_lanes_pd,
    output logic o_frame
);
    // control registers
    logic [15:0] sync_enable_ctrl; // stored only, alignment needs no enable
    logic [15:0] pattern_align_ctrl;
    logic [15:0] output_rate_ctrl;
    logic [15:0] word_format_ctrl;
    logic [15:0] output_mode_ctrl;
    logic [15:0] lane_map_low_0;
    logic [15:0] lane_map_low_1;
    logic [15:0] lane_map_low_2;
    logic [15:0] lane_map_high_0;
    logic [15:0] lane_map_high_1;
    logic [15:0] lane_map_high_2;

    // bus decode
    logic [7:0] reg_idx;
    logic wr_go;
    logic [15:0] rd_mux;

    // sync pin synchroniser and filtered level
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic sync_lvl;
    logic sync_rise;
    logic filt_align;
    logic pat_align;

    // control fields
    logic pattern_align_select;
    logic twos_complement_select;
    logic msb_first_select;
    logic two_wire;
    logic ramp_en;
    aorm_rate_t rate;

    // sample path
    logic [AORM_WORD_W-1:0] ramp;
    aorm_samples_t samp_q;
    logic word_en;
    logic [2:0] div_phase;
    logic [AORM_MAP_W-1:0] lane_code [AORM_LANE_N];
    aorm_lane_sel_t lane_sel [AORM_LANE_N];
    logic [AORM_LANE_N-1:0] ser_bit;
    logic [AORM_LANE_N-1:0] ser_pd;

    // byte-enable merge of a 16-bit register
    function automatic logic [15:0] wmerge(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    // word format: msb inverted for two's complement
    function automatic logic [AORM_WORD_W-1:0] fmt(
        input logic [AORM_WORD_W-1:0] w,
        input logic twos
    );
        logic [AORM_WORD_W-1:0] r;
        r = w;
        r[AORM_WORD_W-1] = w[AORM_WORD_W-1] ^ twos;
        return r;
    endfunction

    // pick channel and half word for one lane from its map code
    function automatic aorm_lane_sel_t lane_pick(
        input logic [AORM_MAP_W-1:0] code,
        input logic upper,
        input aorm_samples_t s,
        input logic half
    );
        aorm_lane_sel_t r;
        logic [2:0] ch;
        logic hi;
        logic [AORM_WORD_W-1:0] w;
        // lower group counts up from channel 1, upper group down from 8
        ch = upper ? 3'(3'h7 - {1'b0, code[2:1]}) : {1'b0, code[2:1]};
        hi = code[0];
        w = s[ch];
        // odd codes are the high 7-bit half word, valid only in 2-wire mode
        r.pd = code[AORM_MAP_PD_BIT] | (hi & ~half);
        if (!half)
            r.word = w;
        else if (hi)
            r.word = {{AORM_HALF_W{1'b0}}, w[AORM_WORD_W-1:AORM_HALF_W]};
        else
            r.word = {{AORM_HALF_W{1'b0}}, w[AORM_HALF_W-1:0]};
        return r;
    endfunction

    // register index from byte address
    assign reg_idx = i_avs_address[AORM_AVS_AW-1:2];
    // a write lands at the edge where waitrequest is seen low
    assign wr_go = i_avs_write & ~o_avs_waitrequest;

    // read selection, unmapped reads give zero
    assign rd_mux =
        (reg_idx == AORM_IDX_SYNC_EN) ? sync_enable_ctrl :
        (reg_idx == AORM_IDX_PAT_ALIGN) ? pattern_align_ctrl :
        (reg_idx == AORM_IDX_MODE) ? output_mode_ctrl :
        (reg_idx == AORM_IDX_STATUS) ? {12'h000, sync_lvl, div_phase} :
        (reg_idx == AORM_IDX_RATE) ? output_rate_ctrl :
        (reg_idx == AORM_IDX_FORMAT) ? word_format_ctrl :
        (reg_idx == AORM_IDX_MAP_L0) ? lane_map_low_0 :
        (reg_idx == AORM_IDX_MAP_L1) ? lane_map_low_1 :
        (reg_idx == AORM_IDX_MAP_L2) ? lane_map_low_2 :
        (reg_idx == AORM_IDX_MAP_H0) ? lane_map_high_0 :
        (reg_idx == AORM_IDX_MAP_H1) ? lane_map_high_1 :
        (reg_idx == AORM_IDX_MAP_H2) ? lane_map_high_2 : 16'h0000;

    // bus handshake: one wait cycle, then answer for one cycle
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end
        else if ((i_avs_read | i_avs_write) && o_avs_waitrequest)
        begin
            // request seen: drop waitrequest with data ready
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= {16'h0000, rd_mux};
        end
        else
            o_avs_waitrequest <= 1'b1;
    end

    // control register writes
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            // defaults keep full rate, offset binary, lsb first
            sync_enable_ctrl <= AORM_RST_CTRL;
            pattern_align_ctrl <= AORM_RST_CTRL;
            output_rate_ctrl <= AORM_RST_CTRL;
            word_format_ctrl <= AORM_RST_CTRL;
            output_mode_ctrl <= AORM_RST_CTRL;
        end
        else if (wr_go)
        begin
            // one register per index, others ignored
            if (reg_idx == AORM_IDX_SYNC_EN)
                sync_enable_ctrl <= wmerge(sync_enable_ctrl, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_PAT_ALIGN)
                pattern_align_ctrl <= wmerge(pattern_align_ctrl, i_avs_writedata,
                                             i_avs_byteenable);
            if (reg_idx == AORM_IDX_RATE)
                output_rate_ctrl <= wmerge(output_rate_ctrl, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_FORMAT)
                word_format_ctrl <= wmerge(word_format_ctrl, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MODE)
                output_mode_ctrl <= wmerge(output_mode_ctrl, i_avs_writedata, i_avs_byteenable);
        end
    end

    // lane map register writes, reset gives the default mapping
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lane_map_low_0 <= AORM_RST_MAP_L0;
            lane_map_low_1 <= AORM_RST_MAP_L1;
            lane_map_low_2 <= AORM_RST_MAP_L2;
            lane_map_high_0 <= AORM_RST_MAP_H0;
            lane_map_high_1 <= AORM_RST_MAP_H1;
            lane_map_high_2 <= AORM_RST_MAP_H2;
        end
        else if (wr_go)
        begin
            if (reg_idx == AORM_IDX_MAP_L0)
                lane_map_low_0 <= wmerge(lane_map_low_0, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MAP_L1)
                lane_map_low_1 <= wmerge(lane_map_low_1, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MAP_L2)
                lane_map_low_2 <= wmerge(lane_map_low_2, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MAP_H0)
                lane_map_high_0 <= wmerge(lane_map_high_0, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MAP_H1)
                lane_map_high_1 <= wmerge(lane_map_high_1, i_avs_writedata, i_avs_byteenable);
            if (reg_idx == AORM_IDX_MAP_H2)
                lane_map_high_2 <= wmerge(lane_map_high_2, i_avs_writedata, i_avs_byteenable);
        end
    end

    // control fields out of the registers
    assign pattern_align_select = pattern_align_ctrl[AORM_PAT_ALIGN_BIT];
    assign twos_complement_select = word_format_ctrl[AORM_TWOS_BIT];
    assign msb_first_select = word_format_ctrl[AORM_MSB_FIRST_BIT];
    assign two_wire = output_mode_ctrl[AORM_MODE_TWO_WIRE_BIT];
    assign ramp_en = output_mode_ctrl[AORM_MODE_RAMP_BIT];
    assign rate = aorm_rate_t'(output_rate_ctrl[AORM_RATE_LSB +: 2]);

    // sync pin through three flops, level taken when stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
            sync_lvl <= 1'b0;
        end
        else
        begin
            sync_s1 <= i_sync_pin;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            // settled level, kept for the status register only
            if (sync_s2 == sync_s3)
                sync_lvl <= sync_s2;
        end
    end

    // rising edge between stages two and three is the internal alignment signal;
    // a one-cycle pulse never sits in both stages at once, so it must count here
    assign sync_rise = sync_s2 & ~sync_s3;
    // pattern select steers the edge to filters or to the ramp
    assign filt_align = sync_rise & ~pattern_align_select;
    assign pat_align = sync_rise & pattern_align_select;

    // ramp test pattern, restarted by pattern alignment
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ramp <= '0;
        else if (pat_align)
            ramp <= '0;
        else if (i_sample_valid)
            ramp <= AORM_WORD_W'(ramp + 1'b1);
    end

    // capture every converter sample; sampling itself is never gated
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            samp_q <= '0;
        else if (i_sample_valid)
        begin
            // the pattern takes the same path and rate as real samples
            for (int c = 0; c < AORM_CH_N; c++)
                samp_q[c] <= fmt(ramp_en ? ramp : i_sample[c], twos_complement_select);
        end
    end

    // output word rate divider; free-running until an alignment edge
    aorm_rate_div u_rate_div (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_tick(i_sample_valid),
        .i_align(filt_align),
        .i_rate(rate),
        .o_en(word_en),
        .o_phase(div_phase)
    );

    // frame marker on the cycle the lanes load a word
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_frame <= 1'b0;
        else
            o_frame <= word_en;
    end

    // lane codes in lane order 1A,1B,2A,...8B; lower group
    assign lane_code[0] = lane_map_low_0[AORM_MAP_F0 +: AORM_MAP_W];
    assign lane_code[1] = lane_map_low_0[AORM_MAP_F1 +: AORM_MAP_W];
    assign lane_code[2] = lane_map_low_0[AORM_MAP_F2 +: AORM_MAP_W];
    assign lane_code[3] = lane_map_low_1[AORM_MAP_F0 +: AORM_MAP_W];
    assign lane_code[4] = lane_map_low_1[AORM_MAP_F1 +: AORM_MAP_W];
    assign lane_code[5] = lane_map_low_1[AORM_MAP_F2 +: AORM_MAP_W];
    assign lane_code[6] = lane_map_low_2[AORM_MAP_F0 +: AORM_MAP_W];
    assign lane_code[7] = lane_map_low_2[AORM_MAP_F1 +: AORM_MAP_W];
    // upper group, b lane before a lane in each register
    assign lane_code[8] = lane_map_high_0[AORM_MAP_F1 +: AORM_MAP_W];
    assign lane_code[9] = lane_map_high_0[AORM_MAP_F0 +: AORM_MAP_W];
    assign lane_code[10] = lane_map_high_1[AORM_MAP_F0 +: AORM_MAP_W];
    assign lane_code[11] = lane_map_high_0[AORM_MAP_F2 +: AORM_MAP_W];
    assign lane_code[12] = lane_map_high_1[AORM_MAP_F2 +: AORM_MAP_W];
    assign lane_code[13] = lane_map_high_1[AORM_MAP_F1 +: AORM_MAP_W];
    assign lane_code[14] = lane_map_high_2[AORM_MAP_F1 +: AORM_MAP_W];
    assign lane_code[15] = lane_map_high_2[AORM_MAP_F0 +: AORM_MAP_W];

    // one serializer per lane, each fed only from its own group
    for (genvar l = 0; l < AORM_LANE_N; l++)
    begin : g_lane
        // lanes 0..7 lower group, 8..15 upper group
        assign lane_sel[l] = lane_pick(lane_code[l], l >= AORM_LANE_N / 2,
                                       samp_q, two_wire);

        aorm_lane_ser u_ser (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_load(word_en),
            .i_word(lane_sel[l].word),
            .i_pd(lane_sel[l].pd),
            .i_half(two_wire),
            .i_msb_first(msb_first_select),
            .o_bit(ser_bit[l]),
            .o_pd(ser_pd[l])
        );
    end

    // sixteen lanes out as a and b pairs
    for (genvar n = 0; n < AORM_LANE_N / 2; n++)
    begin : g_pair
        assign o_lanes.a[n] = ser_bit[2*n];
        assign o_lanes.b[n] = ser_bit[2*n+1];
        assign o_lanes_pd.a[n] = ser_pd[2*n];
        assign o_lanes_pd.b[n] = ser_pd[2*n+1];
    end
endmodule

// ===== tb/aorm_properties.sv
// port checks for the output stage: bus answers, frame timing, lane power-down
`timescale 1ns/1ps
module aorm_properties
    import aorm_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // register bus
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // sample stream and lanes
    input wire logic i_sample_valid,
    input wire aorm_lanes_t o_lanes_pd,
    input wire logic o_frame
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // any request on the bus
    wire req = i_avs_read || i_avs_write;

    // an answer lasts one cycle
    wait_low_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    // an answer needs a request behind it
    answer_cause_a: assert property ($fell(o_avs_waitrequest) |-> $past(req))
        else $error("answer without request");
    // a taken request is answered next cycle
    answer_next_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered");
    // idle bus keeps waitrequest high
    idle_wait_high_a: assert property (!req |=> o_avs_waitrequest)
        else $error("waitrequest low while idle");
    // upper read half is zero
    read_upper_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0)
        else $error("upper read data set");
    // read data move only with an answer
    read_hold_a: assert property ($changed(o_avs_readdata) |-> !o_avs_waitrequest)
        else $error("read data moved");
    // frame marker is one cycle wide
    frame_pulse_a: assert property (o_frame |=> !o_frame)
        else $error("frame too wide");
    // frame comes two edges after a valid sample, sync or not
    frame_cause_a: assert property (o_frame |-> $past(i_sample_valid, 2))
        else $error("frame without sample");
    // lane power-down changes only at a word load
    pd_at_load_a: assert property ($changed(o_lanes_pd) |-> o_frame)
        else $error("power-down moved off load");

    frame_c: cover property (o_frame);
    read_c: cover property (i_avs_read && !o_avs_waitrequest);
    pd_c: cover property ($changed(o_lanes_pd));
endmodule

bind aorm_top aorm_properties u_props (.i_core_clk, .i_rstn, .i_avs_read, .i_avs_write,
    .o_avs_readdata, .o_avs_waitrequest, .i_sample_valid, .o_lanes_pd, .o_frame);

// ===== tb/aorm_lane_rx.sv
// receiver model: takes one word off every lane after each frame marker
`timescale 1ns/1ps
module aorm_lane_rx
(
    // clock
    input wire logic i_core_clk,
    // lanes and frame marker
    input wire logic [15:0] i_lanes,
    input wire logic i_frame,
    // capture setup
    input wire logic i_two_wire,
    input wire logic i_msb_first,
    // captured words
    output logic [15:0][13:0] o_word
);
    int k = 14; // bits taken; idle once at word length
    int n; // word length on the wire
    logic [15:0][13:0] acc; // words being gathered
    // first bit follows the load edge, one bit per cycle
    always @(posedge i_core_clk)
    begin
        n = i_two_wire ? 7 : 14;
        if (k < n)
        begin
            for (int l = 0; l < 16; l++)
                acc[l][i_msb_first ? n - 1 - k : k] = i_lanes[l];
            k++;
            if (k == n)
                o_word = acc;
        end
        if (i_frame)
        begin
            k = 0;
            acc = '0;
        end
    end
endmodule

// ===== tb/test_adc_output_rate_sync_lane_mapper.sv
// bench: registers, output rate, alignment, word format and lane mapping
`timescale 1ns/1ps
module test_adc_output_rate_sync_lane_mapper
    import aorm_pkg::*;
;
    // clock, reset, bus
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [9:0] adr = 10'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat; // data taken at the answer edge
    wire [31:0] rdata;
    wire wreq;
    // stream
    aorm_samples_t smp;
    logic sv = 1'b0;
    logic sp = 1'b0;
    aorm_lanes_t ln;
    aorm_lanes_t lpd;
    wire [15:0] pdv = lpd;
    wire fr;
    wire [15:0][13:0] got;
    // bench state: wire mode, twos complement, msb first, expected map codes
    logic two = 1'b0;
    logic tw = 1'b0;
    logic msb = 1'b0;
    logic [3:0] cd [16];
    logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h0, 3'h6};
    logic [15:0] rmap [6] = '{AORM_RST_MAP_L0, AORM_RST_MAP_L1, AORM_RST_MAP_L2,
        AORM_RST_MAP_H0, AORM_RST_MAP_H1, AORM_RST_MAP_H2};
    int bad_count = 0;
    int checked = 0;
    int frames = 0;
    int f0;

    aorm_top DUT (.i_core_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h3),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_sample(smp),
        .i_sample_valid(sv), .i_sync_pin(sp), .o_lanes(ln), .o_lanes_pd(lpd), .o_frame(fr));
    aorm_lane_rx u_rx (.i_core_clk(clk), .i_lanes(ln), .i_frame(fr), .i_two_wire(two),
        .i_msb_first(msb), .o_word(got));

    // 200 MHz clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // count word loads
    always @(posedge clk)
        if (fr === 1'b1)
            frames++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {16'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        rdat = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 100)
            chk(32'h1, 32'h0);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] want);
        bus(1'b0, idx, 16'h0);
        chk(rdat, want);
    endtask
    // k samples, spaced so each word finishes
    task automatic send(input int k);
        repeat (k)
        begin
            @(posedge clk);
            sv <= 1'b1;
            @(posedge clk);
            sv <= 1'b0;
            repeat (17) @(posedge clk);
        end
    endtask
    // one-cycle alignment pulse, as seen by every chip at once
    task automatic pulse;
        @(posedge clk);
        sp <= 1'b1;
        @(posedge clk);
        sp <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // every lane against the channel its code selects
    task automatic lanes_chk;
        logic [3:0] c;
        logic [13:0] w;
        logic p;
        for (int l = 0; l < 16; l++)
        begin
            c = cd[l];
            w = smp[(l % 8 < 4) ? c[2:1] : 7 - c[2:1]] ^ {tw, 13'h0};
            p = c[3] || (!two && c[0]);
            chk(pdv[l], p);
            if (!p)
                chk(got[l], !two ? w : c[0] ? w[13:7] : w[6:0]);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        $display("[FAIL] %0t watchdog expired", $time);
        bad_count++;
        final_report();
    end

    initial
    begin
        for (int l = 0; l < 16; l++)
            cd[l] = {1'b0, 2'(l % 8 < 4 ? l % 8 : 7 - l % 8), 1'(l / 8)};
        for (int c = 0; c < 8; c++)
            smp[c] = 14'(c * 14'h0731 + 14'h00a5);
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        // reset values and an unmapped place
        foreach (rmap[k])
            rdchk(AORM_IDX_MAP_L0 + 8'(k), {16'h0, rmap[k]});
        rdchk(AORM_IDX_PAT_ALIGN, 32'h0);
        bus(1'b1, 8'h03, 16'hffff);
        rdchk(8'h03, 32'h0);
        $display("registers test done");
        // every rate code after an alignment
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b1, AORM_IDX_RATE, 16'(r));
            rdchk(AORM_IDX_RATE, 32'(r));
            pulse();
            f0 = frames;
            send(8);
            chk(frames - f0, 32'h8 >> r);
        end
        bus(1'b1, AORM_IDX_RATE, 16'h0);
        bus(1'b1, AORM_IDX_MODE, 16'h0002);
        f0 = frames;
        send(3);
        chk(frames - f0, 32'h3);
        bus(1'b1, AORM_IDX_MODE, 16'h0);
        $display("rate test done");
        // pattern select stops filter alignment; dividers run free otherwise
        bus(1'b1, AORM_IDX_RATE, 16'h0001);
        pulse();
        send(1);
        bus(1'b1, AORM_IDX_PAT_ALIGN, 16'h8000);
        pulse();
        f0 = frames;
        send(1);
        chk(frames - f0, 32'h0);
        f0 = frames;
        send(1);
        chk(frames - f0, 32'h1);
        bus(1'b1, AORM_IDX_PAT_ALIGN, 16'h0);
        pulse();
        f0 = frames;
        send(1);
        chk(frames - f0, 32'h1);
        $display("alignment test done");
        // word formats, wire modes and a remap with powered-down lanes
        bus(1'b1, AORM_IDX_RATE, 16'h0);
        foreach (modes[i])
        begin
            {two, tw, msb} = modes[i];
            if (i == 4)
            begin
                bus(1'b1, AORM_IDX_MAP_L0, 16'h0286);
                bus(1'b1, AORM_IDX_MAP_H2, 16'h0069);
                rdchk(AORM_IDX_MAP_L0, 32'h0286);
                cd[0] = 4'h6;
                cd[8] = 4'h8;
                cd[7] = 4'h6;
                cd[15] = 4'h9;
            end
            bus(1'b1, AORM_IDX_MODE, {15'h0, two});
            bus(1'b1, AORM_IDX_FORMAT, {12'h0, msb, tw, 2'b00});
            send(1);
            lanes_chk();
        end
        // ramp restarted by a pulse under pattern select
        bus(1'b1, AORM_IDX_MODE, 16'h0003);
        bus(1'b1, AORM_IDX_PAT_ALIGN, 16'h8000);
        pulse();
        send(1);
        chk(got[1], 32'h0);
        $display("lanes test done");
        final_report();
    end
endmodule
